/* File: core/clkirq_regs.sv */
// clock synchronisation control and first interrupt mask register bank
//
// Overview of operation
// - sync output delayed by phase code times 20 MHz periods; code zero means none
// - output clock select bit picks internal clock one (0) or two (1)
// - writing one to external select bit requests sync input for the loop
// - input divider bit zero passes sync input, one divides it by six
// - modulation enable bit turns oscillator frequency modulation on or off
// - mask bit set blocks its event from the interrupt output; masks clear on reset
// - overcurrent masks at bits 22, 20, 19, 18, 17, 16
// - thermal shutdown masks at bits 13, 12, 11, 10, 9, 8
// - mask register bits 23, 21, 15, 14 reserved, written zero, read zero
`timescale 1ns/100ps
`include "clkirq_params.svh"

module clkirq_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access from the serial control interface
  input wire clkirq_pkg::clkirq_addr_t regAddr,
  input wire logic regWrite,
  input wire clkirq_pkg::clkirq_data_t regWriteData,
  input wire logic regRead,
  output clkirq_pkg::clkirq_data_t regReadData,
  // internal clocks
  input wire logic internalClockOne,
  input wire logic internalClockTwo,
  // synchronisation clocks
  input wire logic syncClockInput,
  output logic syncClockOutput,
  output logic syncInDivided,
  output logic externalSyncSelectRequest,
  // oscillator control
  output logic oscillatorModulationEnable,
  output logic [3:0] oscillatorTune,
  // regulator events and interrupt
  input wire logic [5:0] overcurrentEvent,
  input wire logic [5:0] thermalEvent,
  output logic interruptOut
);

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic logic addrHit(input clkirq_pkg::clkirq_addr_t a, input clkirq_pkg::clkirq_addr_t target);
    addrHit = (a == target);
  endfunction

  function automatic int fieldPos(input int bitNum);
    fieldPos = bitNum - `CLKIRQ_DATA_LSB;
  endfunction

  wire logic clockHit = addrHit(regAddr, `CLKIRQ_ADDR_CLOCK_SYNC_CONFIG);
  wire logic maskHit = addrHit(regAddr, `CLKIRQ_ADDR_INTERRUPT_MASK_ONE);
  wire logic clockWrite = regWrite & clockHit;
  wire logic maskWrite = regWrite & maskHit;

  // ----------------------------------------
  // clock_sync_config storage
  // ----------------------------------------
  logic [2:0] phaseShift_q;
  clkirq_pkg::clkirq_src_t outSource_q;
  logic inDivider_q;
  logic modEnable_q;
  logic [3:0] tune_q;
  logic extRequest_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phaseShift_q <= 3'h0;
      outSource_q <= clkirq_pkg::CLKIRQ_SRC_ONE;
      inDivider_q <= 1'h0;
      modEnable_q <= 1'h0;
      tune_q <= 4'h0;
    end else if (clockWrite) begin
      phaseShift_q <= regWriteData[fieldPos(`CLKIRQ_PHASE_MSB):fieldPos(`CLKIRQ_PHASE_LSB)];
      outSource_q <= clkirq_pkg::clkirq_src_t'(regWriteData[fieldPos(`CLKIRQ_OUT_SRC_BIT)]);
      inDivider_q <= regWriteData[fieldPos(`CLKIRQ_IN_DIV_BIT)];
      modEnable_q <= regWriteData[fieldPos(`CLKIRQ_OSCILLATOR_MODULATION_ENABLE_BIT)];
      tune_q <= regWriteData[fieldPos(`CLKIRQ_TUNE_MSB):fieldPos(`CLKIRQ_TUNE_LSB)];
    end
  end

  // request is a one-cycle pulse; a zero write leaves nothing behind
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      extRequest_q <= 1'h0;
    end else begin
      extRequest_q <= clockWrite & regWriteData[fieldPos(`CLKIRQ_EXT_REQ_BIT)];
    end
  end

  assign externalSyncSelectRequest = extRequest_q;
  assign oscillatorModulationEnable = modEnable_q;
  assign oscillatorTune = tune_q;

  // ----------------------------------------
  // interrupt_mask_one storage
  // ----------------------------------------
  logic [5:0] ocMask_q;
  logic [5:0] tsdMask_q;
  logic intr_q;

  // event index 5..0: prereg/boost, first_step_down, buck2, buck3, linreg1, linreg2
  wire logic [5:0] ocMaskIn = {
    regWriteData[fieldPos(`CLKIRQ_OC_PREREG_BIT)],
    regWriteData[fieldPos(`CLKIRQ_OC_FIRST_STEP_DOWN_BIT)],
    regWriteData[fieldPos(`CLKIRQ_OC_BUCK2_BIT)],
    regWriteData[fieldPos(`CLKIRQ_OC_BUCK3_BIT)],
    regWriteData[fieldPos(`CLKIRQ_OC_LIN1_BIT)],
    regWriteData[fieldPos(`CLKIRQ_OC_LIN2_BIT)]};
  wire logic [5:0] tsdMaskIn = {
    regWriteData[fieldPos(`CLKIRQ_TSD_BOOST_BIT)],
    regWriteData[fieldPos(`CLKIRQ_TSD_FIRST_STEP_DOWN_BIT)],
    regWriteData[fieldPos(`CLKIRQ_TSD_BUCK2_BIT)],
    regWriteData[fieldPos(`CLKIRQ_TSD_BUCK3_BIT)],
    regWriteData[fieldPos(`CLKIRQ_TSD_LIN1_BIT)],
    regWriteData[fieldPos(`CLKIRQ_TSD_LIN2_BIT)]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ocMask_q <= 6'h00;
      tsdMask_q <= 6'h00;
    end else if (maskWrite) begin
      ocMask_q <= ocMaskIn;
      tsdMask_q <= tsdMaskIn;
    end
  end

  wire logic intrD = |(overcurrentEvent & ~ocMask_q) | |(thermalEvent & ~tsdMask_q);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intr_q <= 1'h0;
    end else begin
      intr_q <= intrD;
    end
  end

  assign interruptOut = intr_q;

  // ----------------------------------------
  // read back
  // ----------------------------------------
  clkirq_pkg::clkirq_data_t clockView;
  clkirq_pkg::clkirq_data_t maskView;
  clkirq_pkg::clkirq_data_t readData_q;

  always_comb begin
    clockView = `CLKIRQ_CLOCK_RESET;
    clockView[fieldPos(`CLKIRQ_PHASE_MSB):fieldPos(`CLKIRQ_PHASE_LSB)] = phaseShift_q;
    clockView[fieldPos(`CLKIRQ_OUT_SRC_BIT)] = (outSource_q == clkirq_pkg::CLKIRQ_SRC_TWO);
    clockView[fieldPos(`CLKIRQ_IN_DIV_BIT)] = inDivider_q;
    clockView[fieldPos(`CLKIRQ_OSCILLATOR_MODULATION_ENABLE_BIT)] = modEnable_q;
    clockView[fieldPos(`CLKIRQ_TUNE_MSB):fieldPos(`CLKIRQ_TUNE_LSB)] = tune_q;
  end

  // reserved positions stay at the zero reset pattern
  always_comb begin
    maskView = `CLKIRQ_MASK_RESET;
    maskView[fieldPos(`CLKIRQ_OC_PREREG_BIT)] = ocMask_q[5];
    maskView[fieldPos(`CLKIRQ_OC_FIRST_STEP_DOWN_BIT)] = ocMask_q[4];
    maskView[fieldPos(`CLKIRQ_OC_BUCK2_BIT)] = ocMask_q[3];
    maskView[fieldPos(`CLKIRQ_OC_BUCK3_BIT)] = ocMask_q[2];
    maskView[fieldPos(`CLKIRQ_OC_LIN1_BIT)] = ocMask_q[1];
    maskView[fieldPos(`CLKIRQ_OC_LIN2_BIT)] = ocMask_q[0];
    maskView[fieldPos(`CLKIRQ_TSD_BOOST_BIT)] = tsdMask_q[5];
    maskView[fieldPos(`CLKIRQ_TSD_FIRST_STEP_DOWN_BIT)] = tsdMask_q[4];
    maskView[fieldPos(`CLKIRQ_TSD_BUCK2_BIT)] = tsdMask_q[3];
    maskView[fieldPos(`CLKIRQ_TSD_BUCK3_BIT)] = tsdMask_q[2];
    maskView[fieldPos(`CLKIRQ_TSD_LIN1_BIT)] = tsdMask_q[1];
    maskView[fieldPos(`CLKIRQ_TSD_LIN2_BIT)] = tsdMask_q[0];
  end

  wire clkirq_pkg::clkirq_data_t readSel = clockHit ? clockView : (maskHit ? maskView : 16'h0000);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readData_q <= 16'h0000;
    end else if (regRead) begin
      readData_q <= readSel;
    end
  end

  assign regReadData = readData_q;

  // ----------------------------------------
  // 20 MHz phase tick and output clock delay
  // ----------------------------------------
  localparam logic [2:0] TickLast = 3'(`CLKIRQ_PHASE_TICK_CYCLES - 1);
  logic [2:0] tickCnt_q;
  logic [7:0] history_q;
  logic syncOut_q;

  wire logic phaseTick = (tickCnt_q == TickLast);
  wire logic srcLevel = (outSource_q == clkirq_pkg::CLKIRQ_SRC_TWO) ? internalClockTwo : internalClockOne;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tickCnt_q <= 3'h0;
      history_q <= 8'h00;
    end else begin
      tickCnt_q <= phaseTick ? 3'h0 : tickCnt_q + 3'h1;
      if (phaseTick) begin
        history_q <= {history_q[6:0], srcLevel};
      end
    end
  end

  // tap zero is the live source so code zero adds no delay
  // history_q[0] already holds the newest tick sample, so code n reads history_q[n]: n full ticks, never fewer
  wire logic [7:0] taps = {history_q[7:1], srcLevel};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncOut_q <= 1'h0;
    end else begin
      syncOut_q <= taps[phaseShift_q];
    end
  end

  assign syncClockOutput = syncOut_q;

  // ----------------------------------------
  // sync input divider
  // ----------------------------------------
  localparam logic [1:0] EdgeLast = 2'(`CLKIRQ_IN_HALF_EDGES - 1);
  logic inPrev_q;
  logic [1:0] edgeCnt_q;
  logic divClk_q;
  logic divOut_q;

  wire logic inRise = syncClockInput & ~inPrev_q;

  // toggling every third rising edge gives one output period per six input periods
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inPrev_q <= 1'h0;
      edgeCnt_q <= 2'h0;
      divClk_q <= 1'h0;
    end else begin
      inPrev_q <= syncClockInput;
      if (inRise) begin
        edgeCnt_q <= (edgeCnt_q == EdgeLast) ? 2'h0 : edgeCnt_q + 2'h1;
        if (edgeCnt_q == EdgeLast) begin
          divClk_q <= ~divClk_q;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divOut_q <= 1'h0;
    end else begin
      divOut_q <= inDivider_q ? divClk_q : syncClockInput;
    end
  end

  assign syncInDivided = divOut_q;

endmodule

/* File: include/clkirq_params.svh */
// register offsets, field positions, reset values and timing counts for the clock and mask registers
`ifndef CLKIRQ_PARAMS_SVH
`define CLKIRQ_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CLKIRQ_ADDR_CLOCK_SYNC_CONFIG 8'h0A
`define CLKIRQ_ADDR_INTERRUPT_MASK_ONE 8'h0B

// ----------------------------------------
// clock_sync_config fields (register bit numbers 23..8)
// ----------------------------------------
`define CLKIRQ_PHASE_MSB 18
`define CLKIRQ_PHASE_LSB 16
`define CLKIRQ_OUT_SRC_BIT 15
`define CLKIRQ_EXT_REQ_BIT 14
`define CLKIRQ_IN_DIV_BIT 13
`define CLKIRQ_OSCILLATOR_MODULATION_ENABLE_BIT 12
`define CLKIRQ_TUNE_MSB 11
`define CLKIRQ_TUNE_LSB 8

// ----------------------------------------
// interrupt_mask_one fields
// ----------------------------------------
`define CLKIRQ_OC_PREREG_BIT 22
`define CLKIRQ_OC_FIRST_STEP_DOWN_BIT 20
`define CLKIRQ_OC_BUCK2_BIT 19
`define CLKIRQ_OC_BUCK3_BIT 18
`define CLKIRQ_OC_LIN1_BIT 17
`define CLKIRQ_OC_LIN2_BIT 16
`define CLKIRQ_TSD_BOOST_BIT 13
`define CLKIRQ_TSD_FIRST_STEP_DOWN_BIT 12
`define CLKIRQ_TSD_BUCK2_BIT 11
`define CLKIRQ_TSD_BUCK3_BIT 10
`define CLKIRQ_TSD_LIN1_BIT 9
`define CLKIRQ_TSD_LIN2_BIT 8
`define CLKIRQ_DATA_LSB 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define CLKIRQ_CLOCK_RESET 16'h0000
`define CLKIRQ_MASK_RESET 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define CLKIRQ_SYS_CLK_MHZ 100
`define CLKIRQ_PHASE_CLK_MHZ 20
`define CLKIRQ_PHASE_TICK_CYCLES (`CLKIRQ_SYS_CLK_MHZ / `CLKIRQ_PHASE_CLK_MHZ)
`define CLKIRQ_IN_DIV_RATIO 6
`define CLKIRQ_IN_HALF_EDGES (`CLKIRQ_IN_DIV_RATIO / 2)

`endif

/* File: include/clkirq_pkg.sv */
// types shared by the clock and mask register block
package clkirq_pkg;
  typedef logic [15:0] clkirq_data_t;
  typedef logic [7:0] clkirq_addr_t;
  typedef enum logic {CLKIRQ_SRC_ONE, CLKIRQ_SRC_TWO} clkirq_src_t;
endpackage

/* File: sim/clkirq_host.sv */
// host controller model issuing register reads and writes
`timescale 1ns/100ps
module clkirq_host (
  // clock
  input wire logic clk,
  // register access
  output clkirq_pkg::clkirq_addr_t regAddr,
  output logic regWrite,
  output clkirq_pkg::clkirq_data_t regWriteData,
  output logic regRead,
  input wire clkirq_pkg::clkirq_data_t regReadData
);
  initial begin
    regAddr = 8'h00;
    regWrite = 1'b0;
    regWriteData = 16'h0000;
    regRead = 1'b0;
  end
  task automatic wr(input clkirq_pkg::clkirq_addr_t a, input clkirq_pkg::clkirq_data_t d);
    @(negedge clk);
    regAddr = a;
    regWriteData = a == 8'h0B ? d & 16'h5F3F : d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    // released lines show garbage, never the last value
    regWriteData = ~regWriteData;
    regAddr = ~regAddr;
  endtask
  task automatic rd(input clkirq_pkg::clkirq_addr_t a, output clkirq_pkg::clkirq_data_t d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    regAddr = ~regAddr;
    d = regReadData;
  endtask
endmodule

/* File: sim/clkirq_regs_checker.sv */
// concurrent checks on the clock and mask register block ports
`timescale 1ns/100ps
module clkirq_regs_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  input wire clkirq_pkg::clkirq_addr_t regAddr,
  input wire logic regWrite,
  input wire clkirq_pkg::clkirq_data_t regWriteData,
  input wire logic regRead,
  input wire clkirq_pkg::clkirq_data_t regReadData,
  // clocks, controls and events
  input wire logic internalClockOne,
  input wire logic internalClockTwo,
  input wire logic syncClockInput,
  input wire logic syncClockOutput,
  input wire logic syncInDivided,
  input wire logic externalSyncSelectRequest,
  input wire logic oscillatorModulationEnable,
  input wire logic [3:0] oscillatorTune,
  input wire logic [5:0] overcurrentEvent,
  input wire logic [5:0] thermalEvent,
  input wire logic interruptOut
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] clkQ, mskQ, msk2Q, rdQ;
  logic [11:0] evtQ;
  logic srcQ, reqQ;
  wire wrClk = regWrite && regAddr == 8'h0A;
  wire wrMsk = regWrite && regAddr == 8'h0B;
  // masks lag one extra cycle: the gate uses the value stored before the event edge
  wire [11:0] mBits = {msk2Q[14], msk2Q[12:8], msk2Q[5:0]};
  always_ff @(posedge clk) begin
    clkQ <= !rst_n ? 16'h0000 : wrClk ? regWriteData & 16'h07BF : clkQ;
    mskQ <= !rst_n ? 16'h0000 : wrMsk ? regWriteData & 16'h5F3F : mskQ;
    msk2Q <= mskQ;
    evtQ <= rst_n ? {overcurrentEvent, thermalEvent} : 12'h000;
    rdQ <= regAddr == 8'h0A ? clkQ : regAddr == 8'h0B ? mskQ : 16'h0000;
    srcQ <= clkQ[7] ? internalClockTwo : internalClockOne;
    reqQ <= rst_n && wrClk && regWriteData[6];
  end
  sequence clkWriteS;
    regWrite && regAddr == 8'h0A;
  endsequence
  a_tune_stored: assert property (clkWriteS |=> oscillatorTune == clkQ[3:0])
    else $error("tuning output differs from written field");
  a_mod_enable: assert property (clkWriteS |=> oscillatorModulationEnable == clkQ[4])
    else $error("modulation enable differs from written bit");
  a_request_pulse: assert property (externalSyncSelectRequest == reqQ)
    else $error("select request pulse wrong");
  a_irq_gate: assert property (interruptOut == |(evtQ & ~mBits))
    else $error("interrupt output differs from masked events");
  a_read_back: assert property (regRead |=> regReadData == rdQ)
    else $error("read data differs from stored register");
  a_read_holds: assert property (!regRead |=> $stable(regReadData))
    else $error("read data changed without a read");
  a_div_bypass: assert property (!clkQ[5] |=> syncInDivided == $past(syncClockInput))
    else $error("undivided sync input not passed through");
  a_source_nodelay: assert property (clkQ[10:8] == 3'h0 && $stable(clkQ) |=> syncClockOutput == srcQ)
    else $error("sync output not the selected clock at code zero");
endmodule
bind clkirq_regs clkirq_regs_checker chk (.*);

/* File: sim/tb.sv */
// self-checking bench for the clock and mask register bank
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic internalClockOne = 1'b0;
  logic internalClockTwo = 1'b0;
  logic syncClockInput = 1'b0;
  logic [5:0] overcurrentEvent = 6'h00;
  logic [5:0] thermalEvent = 6'h00;
  clkirq_pkg::clkirq_addr_t regAddr;
  clkirq_pkg::clkirq_data_t regWriteData, regReadData, rdVal;
  logic regWrite, regRead, syncClockOutput, syncInDivided, externalSyncSelectRequest;
  logic oscillatorModulationEnable, interruptOut;
  logic [3:0] oscillatorTune;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  clkirq_regs DUT (.*);
  clkirq_host host (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic t_clock;
    host.rd(8'h0A, rdVal);
    check(rdVal, 16'h0000);
    host.wr(8'h0A, 16'hFFFF);
    check({12'h000, oscillatorTune}, 16'h000F);
    check({14'h0000, externalSyncSelectRequest, oscillatorModulationEnable}, 16'h0003);
    @(negedge clk);
    check({15'h0000, externalSyncSelectRequest}, 16'h0000);
    host.rd(8'h0A, rdVal);
    check(rdVal, 16'h07BF);
    host.wr(8'h0C, 16'hFFFF);
    host.rd(8'h0C, rdVal);
    check(rdVal, 16'h0000);
    host.wr(8'h0A, 16'h0000);
    check({14'h0000, externalSyncSelectRequest, oscillatorModulationEnable}, 16'h0000);
    $display("clock register test done");
  endtask
  task automatic t_mask;
    int pos;
    for (int i = 0; i < 12; i++) begin
      pos = i < 6 ? i : (i == 11 ? 14 : i + 2);
      host.wr(8'h0B, 16'h0001 << pos);
      {overcurrentEvent, thermalEvent} = 12'h001 << i;
      repeat (2) @(negedge clk);
      check({15'h0000, interruptOut}, 16'h0000);
      host.rd(8'h0B, rdVal);
      check(rdVal, 16'h0001 << pos);
      host.wr(8'h0B, 16'h0000);
      repeat (2) @(negedge clk);
      check({15'h0000, interruptOut}, 16'h0001);
      {overcurrentEvent, thermalEvent} = 12'h000;
    end
    $display("mask register test done");
  endtask
  task automatic t_div;
    int rises;
    logic prev;
    rises = 0;
    host.wr(8'h0A, 16'h0020);
    for (int k = 0; k < 100; k++) begin
      prev = syncInDivided;
      syncClockInput = k < 96 && k % 4 < 2;
      @(negedge clk);
      if (prev === 1'b0 && syncInDivided === 1'b1) rises++;
    end
    // 24 input rises give 8 toggles whatever the count phase
    check(rises[15:0], 16'h0004);
    host.wr(8'h0A, 16'h0000);
    $display("divider test done");
  endtask
  task automatic t_phase(input int n, input logic two);
    int cnt;
    cnt = 0;
    internalClockOne = two;
    internalClockTwo = ~two;
    host.wr(8'h0A, {5'h00, n[2:0], two, 7'h00});
    repeat (45) @(negedge clk);
    if (two) internalClockTwo = 1'b1;
    else internalClockOne = 1'b1;
    while (syncClockOutput !== 1'b1 && cnt < 60) begin
      @(negedge clk);
      cnt++;
    end
    // code zero answers at the first negedge; code n adds n ticks of 5 cycles plus up to one tick of alignment
    check({15'h0000, cnt >= n * 5 + 1 && cnt <= n * 5 + 6}, 16'h0001);
    internalClockOne = 1'b0;
    internalClockTwo = 1'b0;
    host.wr(8'h0A, 16'h0000);
    repeat (45) @(negedge clk);
    $display("phase test done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_clock();
    t_mask();
    t_div();
    t_phase(1, 1'b0);
    t_phase(7, 1'b1);
    conclude();
  end
endmodule
